// ### hw/pfd_pkg.sv
// Package with register map, field layout and encodings for the fault PWM
package pfd_pkg;

  // Bus, timer and accumulator widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TIME_W = 12;
  localparam int ACC_W = 8;
  typedef logic [ADDR_W-1:0] pfd_addr_t;
  typedef logic [DATA_W-1:0] pfd_word_t;
  typedef logic [TIME_W-1:0] pfd_time_t;

  // Register byte addresses
  localparam pfd_addr_t REG_CTRL = 8'h00;
  localparam pfd_addr_t REG_FAULT = 8'h04;
  localparam pfd_addr_t REG_TIME_A = 8'h08;
  localparam pfd_addr_t REG_TIME_B = 8'h0c;
  localparam pfd_addr_t REG_DITHER = 8'h10;
  localparam pfd_addr_t REG_STATUS = 8'h14;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WAVE_LSB = 1;
  localparam int CTRL_RESTART_BIT = 8;
  // Fault select fields, one nibble per input
  localparam int FSEL_A_LSB = 0;
  localparam int FSEL_B_LSB = 4;
  // Timing register fields
  localparam int DEAD_LSB = 0;
  localparam int ON_LSB = 16;
  // Dither register fields
  localparam int DPL_LSB = 0;
  localparam int DINC_LSB = 8;
  // Status register fields
  localparam int ST_PHASE_LSB = 0;
  localparam int ST_HALT_BIT = 2;
  localparam int ST_OUT_A_BIT = 3;
  localparam int ST_OUT_B_BIT = 4;
  localparam int ST_WAIT_BIT = 5;
  localparam int ST_DITH_BIT = 6;

  // Reset values and the one-clock count constant
  localparam pfd_time_t TIME_RST = 12'h010;
  localparam logic [ACC_W-1:0] DINC_RST = 8'h00;
  localparam logic [ACC_W-1:0] ACC_RST = 8'h00;
  localparam logic [TIME_W:0] ONE_CNT = 13'h0001;

  // Waveform generation setting
  typedef enum logic [1:0] {
    WG_ONE_RAMP = 2'b00,
    WG_TWO_RAMP = 2'b01,
    WG_FOUR_RAMP = 2'b10,
    WG_DUAL_SLOPE = 2'b11
  } pfd_wave_t;

  // Dither placement select
  typedef enum logic [1:0] {
    DP_ON_B = 2'b00,
    DP_ON_AB = 2'b01,
    DP_DEAD_B = 2'b10,
    DP_DEAD_AB = 2'b11
  } pfd_dplace_t;

  // Counter phase; bit 0 set means on-time
  typedef enum logic [1:0] {
    PH_DEAD_A = 2'b00,
    PH_ON_A = 2'b01,
    PH_DEAD_B = 2'b10,
    PH_ON_B = 2'b11
  } pfd_phase_t;

  // Fault response select codes handled here
  typedef logic [3:0] pfd_fsel_t;
  localparam pfd_fsel_t FM_NONE = 4'h0;
  localparam pfd_fsel_t FM_DEAD_ONLY = 4'h5;
  localparam pfd_fsel_t FM_JUMP_WAIT = 4'h6;
  localparam pfd_fsel_t FM_SW_WAIT = 4'h7;
  localparam pfd_fsel_t FM_EDGE_JUMP = 4'h8;
  localparam pfd_fsel_t FM_EDGE_BLANK = 4'h9;
  localparam pfd_fsel_t FM_LEVEL_BLANK = 4'ha;

endpackage

// ### hw/pfd_fault_if.sv
// Interface carrying conditioned fault events to the sequencer
`timescale 1ns/1ps
interface pfd_fault_if;
  logic [1:0] raw;
  logic [1:0] lvl;
  logic [1:0] rise;
  modport cond (input raw, output lvl, output rise);
  modport seq (output raw, input lvl, input rise);
endinterface

// ### hw/pfd_fault_cond.sv
// Fault event pipeline with level and rising-edge outputs
`timescale 1ns/1ps
module pfd_fault_cond (
  input wire logic clk,
  input wire logic rst_n,
  pfd_fault_if.cond flt
);
  import pfd_pkg::*;

  // Two stages give the event processing latency, third finds edges
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= flt.raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign flt.lvl[gi] = s2_q;
      assign flt.rise[gi] = s2_q & ~s3_q;
    end
  endgenerate
endmodule

// ### hw/pfd_top.sv
// Dead-time PWM sequencer with fault modes 5 to 10, dither and APB
//
// Functional notes
// - Mode 5: on-time event kills outputs, jumps to opposite dead-time.
// - Mode 5: while event holds, alternate dead-times, never enter on-time.
// - Mode 5: after release, running dead-time ends, then normal on-time.
// - Modes 5-7: either input acts alike and affects both outputs.
// - Mode 6: on-time event jumps to opposite dead-time, outputs off.
// - Mode 6: counter halts while the event stays asserted.
// - Mode 6: on release the next dead-time runs, normal flow resumes.
// - Mode 7: event disables both outputs and freezes the counter.
// - Mode 7: frozen until software restart; software must issue it.
// - Mode 7: restart with event still high stops again at once.
// - Mode 7: restart always resumes from dead-time A.
// - Mode 8: rising A in on-time A kills A, jumps to dead-time B.
// - Mode 8: rising B in on-time B kills B, jumps to dead-time A.
// - Mode 9: rising edge blanks matching output for rest of on-time.
// - Mode 9: counter and period untouched, only matching output.
// - Mode 10: asserted input holds matching output off.
// - Mode 10: release within on-time keeps output off until it ends.
// - Mode 10: counter sequence continues undisturbed.
// - Dither accumulates once per cycle; overflow adds one clock to each chosen phase, except on-time A in one ramp.
// - Placement field picks on-time B, both on, dead B, both dead.
// - Added clocks per cycle depend on ramp mode as tabulated.
// - Dual-slope mode gets no dither cycles.
// - Each input has its own response field; other codes do nothing.
// - Fault events reach the outputs two to three clocks after arrival.
`timescale 1ns/1ps
module pfd_top (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire pfd_pkg::pfd_addr_t PADDR,
  input wire pfd_pkg::pfd_word_t PWDATA,
  output pfd_pkg::pfd_word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FAULT_IN_A,
  input wire logic FAULT_IN_B,
  output logic WAVE_OUT_A,
  output logic WAVE_OUT_B
);
  import pfd_pkg::*;

  // Software-visible settings
  logic enable_q;
  pfd_wave_t wave_q;
  pfd_fsel_t fsel_a_q;
  pfd_fsel_t fsel_b_q;
  pfd_time_t dead_a_q;
  pfd_time_t on_a_q;
  pfd_time_t dead_b_q;
  pfd_time_t on_b_q;
  pfd_dplace_t dplace_q;
  logic [ACC_W-1:0] dinc_q;

  // Bus handshake state
  logic pready_q;
  logic pslverr_q;
  pfd_word_t prdata_q;
  logic wr_en;
  logic restart;

  // Sequencer state
  pfd_phase_t phase_q;
  pfd_phase_t phase_d;
  pfd_time_t cnt_q;
  pfd_time_t cnt_d;
  logic stop_q;
  logic stop_d;
  logic wait_q;
  logic wait_d;
  logic blank_a_q;
  logic blank_a_d;
  logic blank_b_q;
  logic blank_b_d;
  logic [ACC_W-1:0] acc_q;
  logic dith_q;
  logic wrap;
  logic out_a_q;
  logic out_b_q;

  // Decoded fault conditions
  logic m5;
  logic m6;
  logic m7;
  logic is_on;
  logic on_a;
  logic on_b;
  logic last;
  logic [1:0] adj;
  logic [TIME_W:0] span;
  pfd_time_t len_cur;

  // Either input with the given code asserted
  function automatic logic any_hit(input pfd_fsel_t sa, input pfd_fsel_t sb,
                                   input logic [1:0] lv, input pfd_fsel_t code);
    any_hit = (sa == code && lv[0]) || (sb == code && lv[1]);
  endfunction

  // Dither effect on a phase: bit 1 lengthens, bit 0 shortens
  function automatic logic [1:0] dith_adj(input pfd_dplace_t pl,
                                          input pfd_wave_t wg,
                                          input pfd_phase_t ph);
    logic in_sel;
    logic dead_sel;
    dith_adj = 2'b00;
    in_sel = 1'b0;
    dead_sel = 1'b0;
    unique case (ph)
      PH_ON_B: begin
        in_sel = (pl == DP_ON_B) || (pl == DP_ON_AB);
        dead_sel = (pl == DP_DEAD_B) || (pl == DP_DEAD_AB);
      end
      PH_ON_A: begin
        // One ramp counts only the B on-time in its period
        in_sel = (pl == DP_ON_AB) && (wg != WG_ONE_RAMP);
        dead_sel = (pl == DP_DEAD_AB);
      end
      PH_DEAD_B: begin
        in_sel = (pl == DP_DEAD_B) || (pl == DP_DEAD_AB);
      end
      PH_DEAD_A: begin
        in_sel = (pl == DP_DEAD_AB);
      end
    endcase
    if (wg == WG_DUAL_SLOPE) begin
      dith_adj = 2'b00;
    end else if (ph[0]) begin
      // On-time: lengthen if chosen, shorten after uncounted dead-time
      dith_adj[1] = in_sel;
      dith_adj[0] = dead_sel && (wg != WG_FOUR_RAMP);
    end else begin
      dith_adj[1] = in_sel;
    end
  endfunction

  // Fault event conditioning, adds the processing latency
  pfd_fault_if flt ();
  assign flt.raw = {FAULT_IN_B, FAULT_IN_A};

  pfd_fault_cond u_cond (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .flt(flt)
  );

  // Global fault modes: both inputs act alike on both outputs
  assign m5 = any_hit(fsel_a_q, fsel_b_q, flt.lvl, FM_DEAD_ONLY);
  assign m6 = any_hit(fsel_a_q, fsel_b_q, flt.lvl, FM_JUMP_WAIT);
  assign m7 = any_hit(fsel_a_q, fsel_b_q, flt.lvl, FM_SW_WAIT);
  assign is_on = phase_q[0];
  assign on_a = (phase_q == PH_ON_A);
  assign on_b = (phase_q == PH_ON_B);

  // Phase length with dither applied; never below one clock
  always_comb begin
    unique case (phase_q)
      PH_DEAD_A: len_cur = dead_a_q;
      PH_ON_A: len_cur = on_a_q;
      PH_DEAD_B: len_cur = dead_b_q;
      PH_ON_B: len_cur = on_b_q;
    endcase
    adj = dith_adj(dplace_q, wave_q, phase_q) & {2{dith_q}};
    span = {1'b0, len_cur} + {{TIME_W{1'b0}}, adj[1]}
           - {{TIME_W{1'b0}}, adj[0]};
    if (span == '0) begin
      span = ONE_CNT;
    end
    last = ({1'b0, cnt_q} + ONE_CNT) >= span;
  end

  // Sequencer next state; priority runs from disable down to normal flow
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q + 1'b1;
    stop_d = stop_q;
    wait_d = wait_q;
    if (!enable_q) begin
      phase_d = PH_DEAD_A;
      cnt_d = '0;
      stop_d = 1'b0;
      wait_d = 1'b0;
    end else if (restart) begin
      phase_d = PH_DEAD_A;
      cnt_d = '0;
      stop_d = m7;
      wait_d = 1'b0;
    end else if (stop_q || m7) begin
      // Frozen until software restarts
      cnt_d = cnt_q;
      stop_d = 1'b1;
    end else if (wait_q) begin
      // Parked at the start of a dead-time
      cnt_d = cnt_q;
      wait_d = m6;
    end else if (is_on && (m5 || m6)) begin
      phase_d = on_a ? PH_DEAD_B : PH_DEAD_A;
      cnt_d = '0;
      wait_d = m6;
    end else if (on_a && fsel_a_q == FM_EDGE_JUMP && flt.rise[0]) begin
      phase_d = PH_DEAD_B;
      cnt_d = '0;
    end else if (on_b && fsel_b_q == FM_EDGE_JUMP && flt.rise[1]) begin
      phase_d = PH_DEAD_A;
      cnt_d = '0;
    end else if (last) begin
      cnt_d = '0;
      if (!is_on && (m5 || m6)) begin
        // Skip the on-time, go straight to the other dead-time
        phase_d = (phase_q == PH_DEAD_A) ? PH_DEAD_B : PH_DEAD_A;
        wait_d = m6;
      end else begin
        phase_d = pfd_phase_t'(phase_q + 2'b01);
      end
    end
  end

  // A new cycle starts whenever dead-time A is entered
  assign wrap = enable_q && (phase_d == PH_DEAD_A) && (phase_q != PH_DEAD_A);

  // Output blanking for modes 9 and 10; a set beats the end-of-on-time clear
  always_comb begin
    blank_a_d = (fsel_a_q == FM_EDGE_BLANK && flt.rise[0] && on_a)
                || (fsel_a_q == FM_LEVEL_BLANK && flt.lvl[0])
                || (blank_a_q && on_a && phase_d == PH_ON_A);
    blank_b_d = (fsel_b_q == FM_EDGE_BLANK && flt.rise[1] && on_b)
                || (fsel_b_q == FM_LEVEL_BLANK && flt.lvl[1])
                || (blank_b_q && on_b && phase_d == PH_ON_B);
  end

  // Counter and phase; blanking modes never touch these
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_q <= PH_DEAD_A;
      cnt_q <= '0;
      stop_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      stop_q <= stop_d;
      wait_q <= wait_d;
    end
  end

  // Blank flags track the on-time they were raised in
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      blank_a_q <= 1'b0;
      blank_b_q <= 1'b0;
    end else begin
      blank_a_q <= blank_a_d;
      blank_b_q <= blank_b_d;
    end
  end

  // Dither accumulator steps once per cycle, carry marks the long cycle
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      acc_q <= ACC_RST;
      dith_q <= 1'b0;
    end else if (!enable_q) begin
      acc_q <= ACC_RST;
      dith_q <= 1'b0;
    end else if (wrap) begin
      {dith_q, acc_q} <= {1'b0, acc_q} + {1'b0, dinc_q};
    end
  end

  // Outputs registered from next state so they match the phase they show
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      out_a_q <= enable_q && !stop_d && (phase_d == PH_ON_A)
                 && !blank_a_d;
      out_b_q <= enable_q && !stop_d && (phase_d == PH_ON_B)
                 && !blank_b_d;
    end
  end

  assign WAVE_OUT_A = out_a_q;
  assign WAVE_OUT_B = out_b_q;

  // APB: ready in the first access cycle, so no wait states
  assign wr_en = PSEL && PENABLE && PWRITE && pready_q;
  assign restart = wr_en && (PADDR == REG_CTRL) && PWDATA[CTRL_RESTART_BIT];

  // Read data and error prepared during the setup cycle
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= PSEL && !PENABLE;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      if (PSEL && !PENABLE) begin
        unique case (PADDR)
          REG_CTRL: begin
            prdata_q[CTRL_EN_BIT] <= enable_q;
            prdata_q[CTRL_WAVE_LSB +: 2] <= wave_q;
          end
          REG_FAULT: begin
            prdata_q[FSEL_A_LSB +: 4] <= fsel_a_q;
            prdata_q[FSEL_B_LSB +: 4] <= fsel_b_q;
          end
          REG_TIME_A: begin
            prdata_q[DEAD_LSB +: TIME_W] <= dead_a_q;
            prdata_q[ON_LSB +: TIME_W] <= on_a_q;
          end
          REG_TIME_B: begin
            prdata_q[DEAD_LSB +: TIME_W] <= dead_b_q;
            prdata_q[ON_LSB +: TIME_W] <= on_b_q;
          end
          REG_DITHER: begin
            prdata_q[DPL_LSB +: 2] <= dplace_q;
            prdata_q[DINC_LSB +: ACC_W] <= dinc_q;
          end
          REG_STATUS: begin
            prdata_q[ST_PHASE_LSB +: 2] <= phase_q;
            prdata_q[ST_HALT_BIT] <= stop_q;
            prdata_q[ST_OUT_A_BIT] <= out_a_q;
            prdata_q[ST_OUT_B_BIT] <= out_b_q;
            prdata_q[ST_WAIT_BIT] <= wait_q;
            prdata_q[ST_DITH_BIT] <= dith_q;
          end
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  // Register writes; reserved fault codes simply act as no action
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      enable_q <= 1'b0;
      wave_q <= WG_ONE_RAMP;
      fsel_a_q <= FM_NONE;
      fsel_b_q <= FM_NONE;
      dead_a_q <= TIME_RST;
      on_a_q <= TIME_RST;
      dead_b_q <= TIME_RST;
      on_b_q <= TIME_RST;
      dplace_q <= DP_ON_B;
      dinc_q <= DINC_RST;
    end else if (wr_en) begin
      unique case (PADDR)
        REG_CTRL: begin
          enable_q <= PWDATA[CTRL_EN_BIT];
          wave_q <= pfd_wave_t'(PWDATA[CTRL_WAVE_LSB +: 2]);
        end
        REG_FAULT: begin
          fsel_a_q <= PWDATA[FSEL_A_LSB +: 4];
          fsel_b_q <= PWDATA[FSEL_B_LSB +: 4];
        end
        REG_TIME_A: begin
          dead_a_q <= PWDATA[DEAD_LSB +: TIME_W];
          on_a_q <= PWDATA[ON_LSB +: TIME_W];
        end
        REG_TIME_B: begin
          dead_b_q <= PWDATA[DEAD_LSB +: TIME_W];
          on_b_q <= PWDATA[ON_LSB +: TIME_W];
        end
        REG_DITHER: begin
          dplace_q <= pfd_dplace_t'(PWDATA[DPL_LSB +: 2]);
          dinc_q <= PWDATA[DINC_LSB +: ACC_W];
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// ### verif/pfd_checker.sv
// Port-level assertions for the fault PWM sequencer
`timescale 1ns/1ps
module pfd_checker (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire pfd_pkg::pfd_addr_t PADDR,
  input wire pfd_pkg::pfd_word_t PWDATA,
  input wire pfd_pkg::pfd_word_t PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic FAULT_IN_A,
  input wire logic FAULT_IN_B,
  input wire logic WAVE_OUT_A,
  input wire logic WAVE_OUT_B
);
  import pfd_pkg::*;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  logic [7:0] fsel_q;
  logic [2:0] run_q;
  logic halt_q;
  logic wr_hit, unmap, stop, m7, lvl_a, lvl_b, m89_a;
  // Decodes of the bus and of the shadowed fault selects
  assign wr_hit = PSEL && PENABLE && PREADY && PWRITE;
  assign unmap = PADDR > REG_STATUS || PADDR[1:0] != 2'h0;
  assign m7 = FAULT_IN_A && fsel_q[3:0] == FM_SW_WAIT ||
    FAULT_IN_B && fsel_q[7:4] == FM_SW_WAIT;
  assign stop = FAULT_IN_A && fsel_q[3:0] inside {[4'h5:4'h7]} ||
    FAULT_IN_B && fsel_q[7:4] inside {[4'h5:4'h7]};
  assign lvl_a = FAULT_IN_A && fsel_q[3:0] == FM_LEVEL_BLANK;
  assign lvl_b = FAULT_IN_B && fsel_q[7:4] == FM_LEVEL_BLANK;
  assign m89_a = fsel_q[3:0] inside {FM_EDGE_JUMP, FM_EDGE_BLANK};
  // Shadow of the fault select register, updated as the write lands
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN)
      fsel_q <= 8'h00;
    else if (wr_hit && PADDR == REG_FAULT)
      fsel_q <= PWDATA[7:0];
  end
  // Freeze tracker; set wins since a restart under fault freezes again
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      run_q <= 3'h0;
      halt_q <= 1'b0;
    end else begin
      run_q <= !m7 ? 3'h0 : (run_q == 3'h4 ? run_q : run_q + 3'h1);
      if (m7 && run_q >= 3'h3)
        halt_q <= 1'b1;
      else if (wr_hit && PADDR == REG_CTRL)
        halt_q <= 1'b0;
    end
  end
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_stop4; stop [*4]; endsequence
  sequence s_edge_a;
    $rose(FAULT_IN_A) && m89_a && WAVE_OUT_A ##1 WAVE_OUT_A [*2];
  endsequence
  property p_ready; s_setup |=> PREADY; endproperty
  property p_rdy_acc; PREADY |-> PSEL && PENABLE; endproperty
  property p_err; PREADY |-> PSLVERR == unmap && (!unmap || PRDATA == '0);
  endproperty
  property p_rd_idle; !PREADY |-> PRDATA == '0; endproperty
  property p_excl; !(WAVE_OUT_A && WAVE_OUT_B); endproperty
  property p_stop; s_stop4 |-> !WAVE_OUT_A && !WAVE_OUT_B; endproperty
  property p_halt; halt_q |-> !WAVE_OUT_A && !WAVE_OUT_B; endproperty
  property p_lvl_a; lvl_a [*4] |-> !WAVE_OUT_A; endproperty
  property p_lvl_b; lvl_b [*4] |-> !WAVE_OUT_B; endproperty
  property p_edge; s_edge_a |=> !WAVE_OUT_A [*2]; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  a_rdy_acc: assert property (p_rdy_acc) else $error("stray ready");
  a_err: assert property (p_err) else $error("bad error response");
  a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
  a_excl: assert property (p_excl) else $error("outputs overlap");
  a_stop: assert property (p_stop) else $error("not stopped");
  a_halt: assert property (p_halt) else $error("ran frozen");
  a_lvl_a: assert property (p_lvl_a) else $error("A not held");
  a_lvl_b: assert property (p_lvl_b) else $error("B not held");
  a_edge: assert property (p_edge) else $error("edge no stop");
endmodule
bind pfd_top pfd_checker i_chk (.REF_CLK, .RSTN, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FAULT_IN_A, .FAULT_IN_B,
  .WAVE_OUT_A, .WAVE_OUT_B);

// ### verif/pfd_evt_src.sv
// Event routing model delivering fault levels, prompt or slow
`timescale 1ns/1ps
module pfd_evt_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] want,
  input wire logic [1:0] slow,
  output logic [1:0] evt
);
  logic [1:0] dly_q;
  // Slow lanes add one routing stage, shifting every reaction a clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_q <= 2'h0;
      evt <= 2'h0;
    end else begin
      dly_q <= want;
      evt <= (slow & dly_q) | (~slow & want);
    end
  end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the fault PWM sequencer
`timescale 1ns/1ps
module testbench;
  import pfd_pkg::*;
  typedef struct {pfd_word_t m; pfd_word_t v; logic e;} pfd_exp_t;
  logic clk, rstn, psel, pen, pwr, prdy, perr, wa, wb;
  pfd_addr_t padr;
  pfd_word_t pwd, prd;
  logic [1:0] want, slow, evt;
  logic [31:0] rs;
  int errors, samples_checked;
  pfd_exp_t q[$];
  pfd_exp_t ex;
  wire [1:0] wo = {wb, wa};
  pfd_top i_dut (.REF_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .FAULT_IN_A(evt[0]), .FAULT_IN_B(evt[1]),
    .WAVE_OUT_A(wa), .WAVE_OUT_B(wb));
  pfd_evt_src i_src (.clk(clk), .rst_n(rstn), .want(want), .slow(slow),
    .evt(evt));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Extra clocks per cycle for each ramp mode and placement
  function automatic int ext(input int w, input int p);
    case (w)
      0: return p < 2 ? 1 : 0;
      1: return p < 2 ? p + 1 : 0;
      2: return p % 2 + 1;
      default: return 0;
    endcase
  endfunction
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input pfd_word_t g, input pfd_word_t x);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic to();
    errors++;
    $display("wait limit hit at %0t", $time);
    test_done();
  endtask
  // Bus cycle: request held until ready is sampled, idle edge after
  task automatic apb(input logic w, input pfd_addr_t a, input pfd_word_t d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    if (n >= 16) to();
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input pfd_addr_t a, input pfd_word_t m, input pfd_word_t v,
      input logic e);
    q.push_back('{m, v, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wrise(input int i, output int n);
    logic p;
    logic hit;
    n = 0;
    p = wo[i];
    do begin
      @(posedge clk);
      n++;
      hit = wo[i] === 1'b1 && p !== 1'b1;
      p = wo[i];
    end while (!hit && n < 600);
    if (!hit) to();
  endtask
  // Sum of two whole periods seen on output A; one period settles first,
  // since the cycle in flight at a setting change carries a stale carry
  task automatic per2(input int x);
    int a;
    int b;
    wrise(0, a);
    wrise(0, a);
    wrise(0, a);
    wrise(0, b);
    chk(a + b, x);
  endtask
  // Fault pulse at the start of an on-time, then status snapshot
  task automatic ev(input int i, input int h, input pfd_word_t v);
    int n;
    wrise(i, n);
    want[i] <= 1'b1;
    repeat (h) @(posedge clk);
    want[i] <= 1'b0;
    // Snapshot after the level has drained, even on the slow lane
    repeat (h + 4) @(posedge clk);
    rd(REG_STATUS, 32'h1b, v, 1'b0);
  endtask
  // Scoreboard: each completed read meets the oldest note
  always @(posedge clk) begin
    if (psel && pen && prdy === 1'b1 && !pwr) begin
      if (q.size() > 0)
        ex = q.pop_front();
      else
        ex = '{32'h0, 32'h1, 1'b0};
      chk(prd & ex.m, ex.v);
      chk({31'h0, perr}, {31'h0, ex.e});
    end
  end
  initial begin
    int n;
    pfd_word_t d;
    errors = 0;
    samples_checked = 0;
    rs = 32'd78;
    {psel, pen, pwr, padr, pwd, want, slow} = '0;
    rstn = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL, '1, 32'h0, 1'b0);
    rd(REG_TIME_A, '1, 32'h00100010, 1'b0);
    rd(REG_TIME_B, '1, 32'h00100010, 1'b0);
    rd(REG_DITHER, '1, 32'h0, 1'b0);
    rd(8'h18, '1, 32'h0, 1'b1);
    apb(1'b1, 8'h1c, xs());
    apb(1'b1, REG_STATUS, '1);
    rd(REG_STATUS, '1, 32'h0, 1'b0);
    d = xs();
    apb(1'b1, REG_FAULT, d);
    rd(REG_FAULT, '1, d & 32'hff, 1'b0);
    $display("test regs done");
    apb(1'b1, REG_TIME_A, 32'h00100006);
    apb(1'b1, REG_TIME_B, 32'h000f0007);
    apb(1'b1, REG_FAULT, 32'hbd);
    apb(1'b1, REG_CTRL, 32'h1);
    want <= 2'b11;
    per2(88);
    want <= 2'b00;
    for (int i = 0; i < 2; i++) begin
      slow <= i ? 2'b11 : 2'b00;
      for (int m = 5; m < 7; m++) begin
        apb(1'b1, REG_FAULT, m << (4 * i));
        want[i] <= 1'b1;
        repeat (100) @(posedge clk);
        rd(REG_STATUS, 32'h21, m == 6 ? 32'h20 : 32'h0, 1'b0);
        want[i] <= 1'b0;
        wrise(0, n);
      end
      apb(1'b1, REG_FAULT, 7 << (4 * i));
      want[i] <= 1'b1;
      repeat (8) @(posedge clk);
      want[i] <= 1'b0;
      repeat (40) @(posedge clk);
      rd(REG_STATUS, 32'h1c, 32'h04, 1'b0);
      apb(1'b1, REG_CTRL, 32'h101);
      rd(REG_STATUS, 32'h1f, 32'h0, 1'b0);
      rd(REG_CTRL, '1, 32'h1, 1'b0);
      want[i] <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b1, REG_CTRL, 32'h101);
      repeat (4) @(posedge clk);
      rd(REG_STATUS, 32'h1f, 32'h04, 1'b0);
      want[i] <= 1'b0;
      // Let the release pass routing and pipeline, else restart re-freezes
      repeat (4) @(posedge clk);
      apb(1'b1, REG_CTRL, 32'h101);
      apb(1'b1, REG_FAULT, 8 << (4 * i));
      ev(i, 2, i ? PH_DEAD_A : PH_DEAD_B);
      apb(1'b1, REG_FAULT, 9 << (4 * i));
      ev(i, 2, i ? PH_ON_B : PH_ON_A);
      per2(88);
      apb(1'b1, REG_FAULT, 10 << (4 * i));
      ev(i, 4, i ? PH_ON_B : PH_ON_A);
      per2(88);
      $display("test faults input %0d done", i);
    end
    apb(1'b1, REG_FAULT, 32'h0);
    for (int w = 0; w < 4; w++) begin
      for (int p = 0; p < 4; p++) begin
        apb(1'b1, REG_CTRL, 1 | (w << 1));
        apb(1'b1, REG_DITHER, 32'h8000 | p);
        per2(88 + ext(w, p));
      end
    end
    $display("test dither done");
    test_done();
  end
endmodule
